// File: rtl/socket_idle_monitor.sv
`timescale 1ns/1ps
module socket_idle_monitor (
  input wire logic clk,
  input wire logic rst,
  input wire logic socket_busy,
  input wire logic host_stop_prep,
  input wire logic clock_stop_policy,
  output logic stop_allowed_r
);

  logic [3:0] idle_count_r;
  logic [3:0] idle_count_nxt;
  logic stop_allowed_nxt;
  logic idle_done;

  always_comb begin
    idle_count_nxt = idle_count_r;
    if (socket_busy) begin
      idle_count_nxt = 4'h0;
    end else if (idle_count_r != socket_supply_pkg::IDLE_COUNT_MAX) begin
      idle_count_nxt = idle_count_r + 4'h1;
    end
    idle_done = (idle_count_nxt == socket_supply_pkg::IDLE_COUNT_MAX);
    // The host clock-run state only gates the card clock when the policy bit is clear.
    stop_allowed_nxt = idle_done && (clock_stop_policy || host_stop_prep);
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      idle_count_r <= 4'h0;
      stop_allowed_r <= 1'b0;
    end else begin
      idle_count_r <= idle_count_nxt;
      stop_allowed_r <= stop_allowed_nxt;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  idle_needs_eight_a: assert property (
    $rose(stop_allowed_r) |-> $past(!socket_busy, 1) && $past(!socket_busy, 8))
    else $error("Card clock stop allowed before eight idle clocks.");

  busy_blocks_stop_a: assert property (
    socket_busy |=> !stop_allowed_r)
    else $error("Card clock stop allowed while socket busy.");

endmodule

// File: rtl/socket_supply_clock_control.sv
// Chosen here: the plain strobed port.
`timescale 1ns/1ps
// Contract
// - Bit 10 reads one, other upper reserved zero.
// - Reserved bit 3 always reads zero.
// - Policy zero: idle eight clocks and host preparing.
// - Policy one: idle eight clocks, host state ignored.
// - Card supply field decode at bits 6..4.
// - Programming supply field decode at bits 2..0.
// - Supply fields survive host reset while events enabled.
// - Unsupported supply levels never reach power switch.
// - Interrogation trigger reloads caps, re-enables auto control.
// - Force capability bits write caps, disable auto control.
module socket_supply_clock_control (
  input wire logic REF_CLK,
  input wire logic RST,
  input wire logic HOST_RST,
  input wire logic PME_ENABLE,
  input wire logic [7:0] REG_ADDR,
  input wire logic [31:0] REG_WDATA,
  input wire logic REG_WR,
  input wire logic REG_RD,
  output logic [31:0] REG_RDATA,
  input wire logic CARD_PRESENT,
  input wire logic [3:0] CARD_CAPS,
  input wire logic SOCKET_BUSY,
  input wire logic HOST_STOP_PREP,
  output logic [2:0] CARD_SUPPLY_OUT,
  output logic [2:0] PROGRAM_SUPPLY_OUT,
  output logic CARD_CLOCK_STOP_OK
);

  socket_supply_pkg::supply_ctrl_type ctrl_r;
  socket_supply_pkg::supply_ctrl_type ctrl_nxt;
  socket_supply_pkg::card_caps_type caps_r;
  socket_supply_pkg::card_caps_type caps_nxt;
  logic auto_power_r;
  logic auto_power_nxt;
  logic bad_request_r;
  logic bad_request_nxt;
  logic [2:0] card_out_r;
  logic [2:0] card_out_nxt;
  logic [2:0] program_out_r;
  logic [2:0] program_out_nxt;
  logic [31:0] rdata_r;
  logic [31:0] rdata_nxt;
  logic wr_control;
  logic wr_force;
  logic card_ok;
  logic program_ok;

  // Supply level allowed for a card with the given capabilities.
  function automatic logic level_ok(input logic [2:0] code,
                                    input socket_supply_pkg::card_caps_type caps);
    logic ok;
    ok = 1'b0;
    unique case (code)
      socket_supply_pkg::SUPPLY_5V: ok = caps.v5;
      socket_supply_pkg::SUPPLY_3V3: ok = caps.v3;
      socket_supply_pkg::SUPPLY_XV: ok = caps.xv;
      socket_supply_pkg::SUPPLY_YV: ok = caps.yv;
      default: ok = 1'b0;
    endcase
    return ok;
  endfunction

  // Read image of the control register with its fixed reserved bits.
  function automatic logic [31:0] control_image(input socket_supply_pkg::supply_ctrl_type c);
    logic [31:0] img;
    img = 32'h0000_0000;
    img[socket_supply_pkg::ONE_BIT] = 1'b1;
    img[socket_supply_pkg::POLICY_BIT] = c.clock_stop_policy;
    img[socket_supply_pkg::CARD_SUPPLY_LSB +: 3] = c.card_supply_request;
    img[socket_supply_pkg::PROGRAM_SUPPLY_LSB +: 3] = c.program_supply_request;
    return img;
  endfunction

  assign wr_control = REG_WR && (REG_ADDR == socket_supply_pkg::SUPPLY_CONTROL_OFS);
  assign wr_force = REG_WR && (REG_ADDR == socket_supply_pkg::FORCE_EVENT_OFS);

  always_comb begin
    ctrl_nxt = ctrl_r;
    if (HOST_RST) begin
      // The policy bit is not context state, so host reset always clears it.
      ctrl_nxt.clock_stop_policy = 1'b0;
      if (!PME_ENABLE) begin
        ctrl_nxt.card_supply_request = socket_supply_pkg::SUPPLY_OFF;
        ctrl_nxt.program_supply_request = socket_supply_pkg::SUPPLY_OFF;
      end
    end else if (wr_control) begin
      // Only the writable fields are taken; reserved positions are rebuilt on read.
      ctrl_nxt.clock_stop_policy = REG_WDATA[socket_supply_pkg::POLICY_BIT];
      ctrl_nxt.card_supply_request = REG_WDATA[socket_supply_pkg::CARD_SUPPLY_LSB +: 3];
      ctrl_nxt.program_supply_request = REG_WDATA[socket_supply_pkg::PROGRAM_SUPPLY_LSB +: 3];
    end
  end

  always_comb begin
    caps_nxt = caps_r;
    auto_power_nxt = auto_power_r;
    if (HOST_RST) begin
      caps_nxt = socket_supply_pkg::CAPS_RESET;
      auto_power_nxt = 1'b1;
    end else if (wr_force && REG_WDATA[socket_supply_pkg::INTERROGATE_BIT]) begin
      caps_nxt = CARD_CAPS;
      auto_power_nxt = 1'b1;
    end else if (wr_force && (REG_WDATA[socket_supply_pkg::FORCE_CAP_LSB +: 4] != 4'h0)) begin
      caps_nxt = REG_WDATA[socket_supply_pkg::FORCE_CAP_LSB +: 4];
      auto_power_nxt = 1'b0;
    end else if (auto_power_r) begin
      // Under automatic control the capabilities track the sensed card.
      caps_nxt = CARD_CAPS;
    end
  end

  always_comb begin
    card_ok = CARD_PRESENT && level_ok(ctrl_r.card_supply_request, caps_r);
    program_ok = card_ok;
    unique case (ctrl_r.program_supply_request)
      socket_supply_pkg::SUPPLY_OFF: program_ok = 1'b1;
      socket_supply_pkg::SUPPLY_12V: program_ok = card_ok;
      default: program_ok = card_ok && level_ok(ctrl_r.program_supply_request, caps_r);
    endcase
    // A refused request drives the switch off rather than holding a stale level.
    card_out_nxt = card_ok ? ctrl_r.card_supply_request : socket_supply_pkg::SUPPLY_OFF;
    program_out_nxt = (card_ok && program_ok) ? ctrl_r.program_supply_request
                                              : socket_supply_pkg::SUPPLY_OFF;
    bad_request_nxt = (ctrl_r.card_supply_request != socket_supply_pkg::SUPPLY_OFF && !card_ok)
                      || !program_ok;
  end

  always_comb begin
    rdata_nxt = 32'h0000_0000;
    if (REG_RD) begin
      unique case (REG_ADDR)
        socket_supply_pkg::SUPPLY_CONTROL_OFS: rdata_nxt = control_image(ctrl_r);
        socket_supply_pkg::PRESENT_STATE_OFS: begin
          rdata_nxt[socket_supply_pkg::PRESENT_CAP_LSB +: 4] = caps_r;
          rdata_nxt[socket_supply_pkg::PRESENT_BAD_REQ_BIT] = bad_request_r;
          rdata_nxt[socket_supply_pkg::PRESENT_CARD_BIT] = CARD_PRESENT;
        end
        default: rdata_nxt = 32'h0000_0000;
      endcase
    end
  end

  // Global reset clears everything except auto_power_r, which it sets to one; the host reset is handled synchronously above.
  always_ff @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      ctrl_r <= socket_supply_pkg::SUPPLY_CTRL_RESET;
      caps_r <= socket_supply_pkg::CAPS_RESET;
      auto_power_r <= 1'b1;
      bad_request_r <= 1'b0;
      card_out_r <= socket_supply_pkg::SUPPLY_OFF;
      program_out_r <= socket_supply_pkg::SUPPLY_OFF;
      rdata_r <= 32'h0000_0000;
    end else begin
      ctrl_r <= ctrl_nxt;
      caps_r <= caps_nxt;
      auto_power_r <= auto_power_nxt;
      bad_request_r <= bad_request_nxt;
      card_out_r <= card_out_nxt;
      program_out_r <= program_out_nxt;
      rdata_r <= rdata_nxt;
    end
  end

  socket_idle_monitor idle_monitor (
    .clk(REF_CLK),
    .rst(RST),
    .socket_busy(SOCKET_BUSY),
    .host_stop_prep(HOST_STOP_PREP),
    .clock_stop_policy(ctrl_r.clock_stop_policy),
    .stop_allowed_r(CARD_CLOCK_STOP_OK)
  );

  assign REG_RDATA = rdata_r;
  assign CARD_SUPPLY_OUT = card_out_r;
  assign PROGRAM_SUPPLY_OUT = program_out_r;

  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (RST);

  reserved_read_fixed_a: assert property (
    REG_RD && REG_ADDR == socket_supply_pkg::SUPPLY_CONTROL_OFS
    |=> REG_RDATA[31:11] == 21'h0 && REG_RDATA[10] && REG_RDATA[9:8] == 2'h0)
    else $error("Control reserved bits read wrong.");

  gap_bit_zero_a: assert property (
    REG_RD && REG_ADDR == socket_supply_pkg::SUPPLY_CONTROL_OFS |=> !REG_RDATA[3])
    else $error("Control bit 3 read as one.");

  policy_gates_host_a: assert property (
    $rose(CARD_CLOCK_STOP_OK) && !$past(ctrl_r.clock_stop_policy)
    |-> $past(HOST_STOP_PREP, 1))
    else $error("Card clock stop allowed without host preparing.");

  policy_ignores_host_a: assert property (
    (ctrl_r.clock_stop_policy && !SOCKET_BUSY) [*8] ##1 ctrl_r.clock_stop_policy
    |-> CARD_CLOCK_STOP_OK)
    else $error("Card clock stop not allowed after eight idle clocks.");

  write_readback_a: assert property (
    wr_control && !HOST_RST ##1 REG_RD && REG_ADDR == socket_supply_pkg::SUPPLY_CONTROL_OFS
    |=> REG_RDATA[7:4] == $past(REG_WDATA[7:4], 2)
        && REG_RDATA[2:0] == $past(REG_WDATA[2:0], 2))
    else $error("Control fields did not read back as written.");

  context_kept_a: assert property (
    HOST_RST && PME_ENABLE |=> ctrl_r.card_supply_request == $past(ctrl_r.card_supply_request)
                               && ctrl_r.program_supply_request
                                  == $past(ctrl_r.program_supply_request))
    else $error("Supply fields lost on host reset with events enabled.");

  context_cleared_a: assert property (
    HOST_RST && !PME_ENABLE |=> ctrl_r.card_supply_request == socket_supply_pkg::SUPPLY_OFF
                                && ctrl_r.program_supply_request == socket_supply_pkg::SUPPLY_OFF)
    else $error("Supply fields kept on host reset with events disabled.");

  supply_acceptable_a: assert property (
    CARD_SUPPLY_OUT != socket_supply_pkg::SUPPLY_OFF
    |-> $past(CARD_PRESENT) && level_ok(CARD_SUPPLY_OUT, $past(caps_r)))
    else $error("Unsupported card supply applied.");

  interrogate_reload_a: assert property (
    wr_force && !HOST_RST && REG_WDATA[socket_supply_pkg::INTERROGATE_BIT]
    |=> auto_power_r && caps_r == $past(CARD_CAPS))
    else $error("Interrogation did not reload capabilities.");

  force_caps_a: assert property (
    wr_force && !HOST_RST && !REG_WDATA[socket_supply_pkg::INTERROGATE_BIT]
    && REG_WDATA[13:10] != 4'h0 |=> !auto_power_r && caps_r == $past(REG_WDATA[13:10]))
    else $error("Forced capabilities not applied.");

  five_volt_code_a: assert property (
    ctrl_r.card_supply_request == socket_supply_pkg::SUPPLY_5V && caps_r.v5 && CARD_PRESENT
    |=> CARD_SUPPLY_OUT == socket_supply_pkg::SUPPLY_5V)
    else $error("Code 010 did not apply 5 V.");

  cover_stop_c: cover property (!ctrl_r.clock_stop_policy ##1 $rose(CARD_CLOCK_STOP_OK));
  cover_supply_c: cover property (CARD_SUPPLY_OUT == socket_supply_pkg::SUPPLY_3V3);
  cover_kept_c: cover property (HOST_RST && PME_ENABLE
                                && ctrl_r.card_supply_request != socket_supply_pkg::SUPPLY_OFF);

endmodule

// File: rtl/socket_supply_pkg.sv
package socket_supply_pkg;

  localparam logic [7:0] PRESENT_STATE_OFS = 8'h08;
  localparam logic [7:0] FORCE_EVENT_OFS = 8'h0C;
  localparam logic [7:0] SUPPLY_CONTROL_OFS = 8'h10;

  localparam int POLICY_BIT = 7;
  localparam int CARD_SUPPLY_LSB = 4;
  localparam int PROGRAM_SUPPLY_LSB = 0;
  localparam int ONE_BIT = 10;
  localparam int INTERROGATE_BIT = 14;
  localparam int FORCE_CAP_LSB = 10;
  localparam int PRESENT_CAP_LSB = 10;
  localparam int PRESENT_BAD_REQ_BIT = 9;
  localparam int PRESENT_CARD_BIT = 0;

  localparam logic [31:0] SUPPLY_CONTROL_RESET = 32'h0000_0000;
  localparam logic [2:0] SUPPLY_OFF = 3'h0;
  localparam logic [2:0] SUPPLY_12V = 3'h1;
  localparam logic [2:0] SUPPLY_5V = 3'h2;
  localparam logic [2:0] SUPPLY_3V3 = 3'h3;
  localparam logic [2:0] SUPPLY_XV = 3'h4;
  localparam logic [2:0] SUPPLY_YV = 3'h5;

  localparam int IDLE_CLOCKS = 8;
  localparam logic [3:0] IDLE_COUNT_MAX = 4'(IDLE_CLOCKS);

  typedef struct packed {
    logic clock_stop_policy;
    logic [2:0] card_supply_request;
    logic [2:0] program_supply_request;
  } supply_ctrl_type;

  // Capability order: YV, XV, 3.3 V, 5 V, matching force bits 13..10.
  typedef struct packed {
    logic yv;
    logic xv;
    logic v3;
    logic v5;
  } card_caps_type;

  localparam supply_ctrl_type SUPPLY_CTRL_RESET = '{1'b0, SUPPLY_OFF, SUPPLY_OFF};
  localparam card_caps_type CAPS_RESET = '{1'b0, 1'b0, 1'b0, 1'b0};

endpackage

// File: tb/card_socket_model.sv
`timescale 1ns/1ps
module card_socket_model (
  input wire logic clk,
  input wire logic inserted,
  input wire logic [3:0] sensed,
  input wire logic [2:0] card_supply,
  input wire logic [2:0] program_supply,
  output logic present,
  output logic [3:0] caps,
  output logic bad_power
);
  // An empty socket senses no capability, so its sense lines read low.
  assign present = inserted;
  assign caps = inserted ? sensed : 4'h0;
  function automatic logic fits(input logic [2:0] c);
    return c >= 3'h2 && c <= 3'h5 && caps[c - 3'h2];
  endfunction
  // The flag is registered so that it never glitches while both codes settle.
  always @(posedge clk) begin
    bad_power <= (card_supply != 3'h0 && (!present || !fits(card_supply))) ||
      (program_supply != 3'h0 && card_supply == 3'h0) ||
      (program_supply > 3'h1 && !fits(program_supply));
  end
endmodule

// File: tb/socket_supply_clock_control_tb.sv
`timescale 1ns/1ps
module socket_supply_clock_control_tb;
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  logic host_rst = 1'b0;
  logic pme = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic inserted = 1'b1;
  logic [3:0] sensed = 4'h0;
  logic busy = 1'b1;
  logic prep = 1'b0;
  logic [31:0] rdata;
  logic present;
  logic bad;
  logic [3:0] caps;
  logic [2:0] vcc;
  logic [2:0] vpp;
  logic stop_ok;
  logic [31:0] d;
  int mismatches = 0;
  int checked = 0;
  int k;

  socket_supply_clock_control DUT (.REF_CLK(ref_clk), .RST(rst), .HOST_RST(host_rst),
    .PME_ENABLE(pme), .REG_ADDR(addr), .REG_WDATA(wdata), .REG_WR(wr), .REG_RD(rd),
    .REG_RDATA(rdata), .CARD_PRESENT(present), .CARD_CAPS(caps), .SOCKET_BUSY(busy),
    .HOST_STOP_PREP(prep), .CARD_SUPPLY_OUT(vcc), .PROGRAM_SUPPLY_OUT(vpp),
    .CARD_CLOCK_STOP_OK(stop_ok));

  card_socket_model partner (.clk(ref_clk), .inserted(inserted), .sensed(sensed),
    .card_supply(vcc), .program_supply(vpp), .present(present), .caps(caps),
    .bad_power(bad));

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      mismatches++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic wr_reg(input logic [7:0] a, input logic [31:0] x);
    @(posedge ref_clk);
    wr <= 1'b1;
    addr <= a;
    wdata <= x;
    @(posedge ref_clk);
    wr <= 1'b0;
  endtask

  task automatic rd_reg(input logic [7:0] a, output logic [31:0] x);
    @(posedge ref_clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge ref_clk);
    rd <= 1'b0;
    #1 x = rdata;
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask

  function automatic int fits(input int c, input int cp);
    return (c >= 2 && c <= 5) ? (cp >> (c - 2)) & 1 : 0;
  endfunction

  // Expected {card, program} codes; the program supply needs the card supply first.
  function automatic int exp_supply(input int c, input int q, input int cp, input int pr);
    int a;
    a = (pr != 0 && fits(c, cp) != 0) ? c : 0;
    return (a != 0 && (q <= 1 || fits(q, cp) != 0)) ? a * 8 + q : a * 8;
  endfunction

  task automatic complete_run;
    $display("checks=%0d mismatches=%0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  initial begin
    forever #12.5 ref_clk = ~ref_clk;
  end

  initial begin
    repeat (20000) @(posedge ref_clk);
    mismatches++;
    complete_run();
  end

  initial begin
    void'($urandom(32'hAEF3A547));
    repeat (6) @(posedge ref_clk);
    rst <= 1'b0;
    rd_reg(8'h10, d);
    chk(d, 32'h0000_0400);
    wr_reg(8'h10, 32'hFFFF_FFFF);
    rd_reg(8'h10, d);
    chk(d, 32'h0000_04F7);
    wr_reg(8'h44, 32'hFFFF_FFFF);
    rd_reg(8'h44, d);
    chk(d, 32'h0);
    // Back-to-back write then read must see the new fields and the fixed reserved bits.
    @(posedge ref_clk);
    wr <= 1'b1;
    addr <= 8'h10;
    wdata <= 32'hFFFF_FB7D;
    @(posedge ref_clk);
    wr <= 1'b0;
    rd <= 1'b1;
    @(posedge ref_clk);
    rd <= 1'b0;
    #1;
    chk(rdata, 32'h0000_0475);
    for (int i = 0; i < 32; i++) begin
      k = int'($urandom() % 16);
      @(posedge ref_clk);
      sensed <= 4'(k);
      inserted <= (i % 5) != 0;
      wr_reg(8'h10, 32'((i % 8) * 16 + (i / 4) % 8));
      cyc(2);
      chk({26'h0, vcc, vpp}, 32'(exp_supply(i % 8, (i / 4) % 8, k, i % 5)));
      chk({31'h0, bad}, 32'h0);
    end
    // Forced capability must win over what the card senses.
    @(posedge ref_clk);
    sensed <= 4'h0;
    inserted <= 1'b1;
    wr_reg(8'h10, 32'h30);
    wr_reg(8'h0C, 32'h800);
    cyc(2);
    chk({29'h0, vcc}, 32'h3);
    rd_reg(8'h08, d);
    chk((d >> 10) & 32'hF, 32'h2);
    wr_reg(8'h0C, 32'h4000);
    cyc(2);
    chk({29'h0, vcc}, 32'h0);
    @(posedge ref_clk);
    sensed <= 4'hF;
    for (int m = 0; m < 2; m++) begin
      wr_reg(8'h10, 32'hB1);
      @(posedge ref_clk);
      pme <= (m == 0);
      host_rst <= 1'b1;
      @(posedge ref_clk);
      host_rst <= 1'b0;
      rd_reg(8'h10, d);
      chk(d, (m == 0) ? 32'h431 : 32'h400);
    end
    wr_reg(8'h10, 32'h31);
    @(posedge ref_clk);
    pme <= 1'b1;
    rst <= 1'b1;
    @(posedge ref_clk);
    rst <= 1'b0;
    rd_reg(8'h10, d);
    chk(d, 32'h400);
    wr_reg(8'h10, 32'h80);
    @(posedge ref_clk);
    busy <= 1'b0;
    cyc(7);
    chk({31'h0, stop_ok}, 32'h0);
    cyc(1);
    chk({31'h0, stop_ok}, 32'h1);
    wr_reg(8'h10, 32'h0);
    cyc(2);
    chk({31'h0, stop_ok}, 32'h0);
    @(posedge ref_clk);
    prep <= 1'b1;
    cyc(2);
    chk({31'h0, stop_ok}, 32'h1);
    @(posedge ref_clk);
    busy <= 1'b1;
    cyc(2);
    chk({31'h0, stop_ok}, 32'h0);
    complete_run();
  end
endmodule
